// ==== elc_pkg.sv ====
// Constants for the E1 line loopback and elastic store control block
package elc_pkg;
  localparam int unsigned PCLK_HZ         = 25000000;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0]  IDX_LOOP_CTRL   = 8'h14;
  localparam logic [7:0]  IDX_LINE_ESTORE = 8'h15;
  localparam logic [7:0]  IDX_DRV_PATTERN = 8'h16;
  localparam logic [7:0]  IDX_COMMON_SEV  = 8'h1F;
  localparam logic [7:0]  IDX_COMMON_SIX  = 8'h2F;
  localparam logic [7:0]  IDX_SLOT_MON    = 8'h30;
  // Loop control register
  localparam int unsigned BIT_LOCAL_LOOP  = 6;
  // Line and elastic store control register
  localparam int unsigned BIT_LINE_RST    = 7;
  localparam int unsigned BIT_ES_ALIGN    = 6;
  localparam int unsigned BIT_ES_RESET    = 5;
  localparam int unsigned MON_SEL_MSB     = 4;
  localparam int unsigned MON_SEL_LSB     = 0;
  // Line driver and pattern control register
  localparam int unsigned BIT_OPEN_DRAIN  = 7;
  localparam int unsigned BIT_DISC_PAT    = 6;
  localparam int unsigned BIT_SYNC_IF     = 5;
  localparam int unsigned BIT_RX_TERM     = 4;
  localparam int unsigned TX_PAT_MSB      = 3;
  localparam int unsigned TX_PAT_LSB      = 2;
  localparam int unsigned RX_PAT_MSB      = 1;
  localparam int unsigned RX_PAT_LSB      = 0;
  // Common control seven and six
  localparam int unsigned BIT_TX_SYNC     = 0;
  localparam int unsigned BIT_SW_RESET    = 0;
  localparam int unsigned SLOT_W          = 5;
  localparam int unsigned DATA_W          = 8;
endpackage

// ==== elc_slot_monitor.sv ====
// Receive time slot monitor capture register
`timescale 1ns/10ps
module elc_slot_monitor (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          clear,
  input  wire logic [elc_pkg::SLOT_W-1:0]    slot_sel,
  input  wire logic [elc_pkg::SLOT_W-1:0]    slot_num,
  input  wire logic [elc_pkg::DATA_W-1:0]    slot_data,
  input  wire logic                          slot_valid,
  output logic      [elc_pkg::DATA_W-1:0]    mon_data
);
  typedef struct packed {
    logic [elc_pkg::DATA_W-1:0] data;
  } elc_mon_s;

  elc_mon_s st;
  elc_mon_s next_st;

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.data = elc_pkg::REG_RESET;
    end else if (slot_valid && slot_num == slot_sel) begin
      next_st.data = slot_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mon_data = st.data;
endmodule

// ==== elc_line_ctrl.sv ====
// E1 line loopback, elastic store command and line driver control with APB slave
`timescale 1ns/10ps
module elc_line_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_pos_in,
  input  wire logic        tx_neg_in,
  input  wire logic        tx_bit_en,
  output logic             line_tx_pos_o,
  output logic             line_tx_pos_oe,
  output logic             line_tx_neg_o,
  output logic             line_tx_neg_oe,
  input  wire logic        line_rx_pos,
  input  wire logic        line_rx_neg,
  output logic             ja_in_pos,
  output logic             ja_in_neg,
  input  wire logic        ja_out_pos,
  input  wire logic        ja_out_neg,
  output logic             rx_pos_out,
  output logic             rx_neg_out,
  input  wire logic        estore_sep_lt_half,
  output logic             line_side_reset_pulse,
  output logic             estore_align_pulse,
  output logic             estore_reset_pulse,
  output logic             rx_term_75,
  output logic             tx_sync_mode,
  output logic             rx_sync_mode,
  output logic [1:0]       tx_pattern_mode,
  output logic [1:0]       rx_pattern_mode,
  input  wire logic [4:0]  rx_slot_num,
  input  wire logic [7:0]  rx_slot_data,
  input  wire logic        rx_slot_valid
);
  typedef struct packed {
    logic        local_loop_enable;
    logic [7:0]  line_and_elastic_store_control;
    logic [7:0]  line_driver_and_pattern_control;
    logic        tx_sync_signal_sel;
    logic        sw_reset;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        lrst_p;
    logic        align_p;
    logic        esrst_p;
    logic        txp;
    logic        txn;
    logic        txp_oe;
    logic        txn_oe;
    logic        jap;
    logic        jan;
    logic        rxp;
    logic        rxn;
    logic        pat_bit;
    logic        pat_pol;
    logic        term;
    logic        txsync;
    logic        rxsync;
    logic [1:0]  txpat;
    logic [1:0]  rxpat;
  } elc_state_s;

  elc_state_s st;
  elc_state_s next_st;
  logic [7:0] mon_data;
  logic [7:0] idx;
  logic       acc;
  logic       wr;
  logic       mapped;
  logic       sw_clear;
  logic       cur_p;
  logic       cur_n;
  logic       pos_drv;
  logic       neg_drv;
  logic [7:0] c4;
  logic [7:0] c5;

  assign idx = paddr[9:2];
  assign acc = psel && penable && st.ready;
  assign wr  = acc && pwrite && !st.slverr;

  // Clear pulse reaches the monitor register too
  assign sw_clear = wr && idx == elc_pkg::IDX_COMMON_SIX && pwdata[elc_pkg::BIT_SW_RESET] && !st.sw_reset;

  elc_slot_monitor u_mon (
    .pclk       (pclk),
    .presetn    (presetn),
    .clear      (sw_clear),
    .slot_sel   (st.line_and_elastic_store_control[elc_pkg::MON_SEL_MSB:elc_pkg::MON_SEL_LSB]),
    .slot_num   (rx_slot_num),
    .slot_data  (rx_slot_data),
    .slot_valid (rx_slot_valid),
    .mon_data   (mon_data)
  );

  always_comb begin
    next_st = st;
    mapped  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
              (idx == elc_pkg::IDX_LOOP_CTRL || idx == elc_pkg::IDX_LINE_ESTORE ||
               idx == elc_pkg::IDX_DRV_PATTERN || idx == elc_pkg::IDX_COMMON_SEV ||
               idx == elc_pkg::IDX_COMMON_SIX || idx == elc_pkg::IDX_SLOT_MON);
    // One wait-free access phase: answer registered during setup
    next_st.ready  = psel && !penable && !st.ready;
    next_st.slverr = psel && !penable && !st.ready && !mapped;
    if (psel && !penable) begin
      next_st.rdata = 32'h0000_0000;
      // Refused addresses read as zero, never as an aliased register
      if (!pwrite && mapped) begin
        unique case (idx)
          elc_pkg::IDX_LOOP_CTRL:   next_st.rdata[elc_pkg::BIT_LOCAL_LOOP] = st.local_loop_enable;
          elc_pkg::IDX_LINE_ESTORE: next_st.rdata[7:0] = st.line_and_elastic_store_control;
          elc_pkg::IDX_DRV_PATTERN: next_st.rdata[7:0] = st.line_driver_and_pattern_control;
          elc_pkg::IDX_COMMON_SEV:  next_st.rdata[elc_pkg::BIT_TX_SYNC] = st.tx_sync_signal_sel;
          elc_pkg::IDX_COMMON_SIX:  next_st.rdata[elc_pkg::BIT_SW_RESET] = st.sw_reset;
          elc_pkg::IDX_SLOT_MON:    next_st.rdata[7:0] = mon_data;
          default:                  next_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    next_st.lrst_p  = 1'b0;
    next_st.align_p = 1'b0;
    next_st.esrst_p = 1'b0;
    if (wr) begin
      unique case (idx)
        elc_pkg::IDX_LOOP_CTRL:   next_st.local_loop_enable = pwdata[elc_pkg::BIT_LOCAL_LOOP];
        elc_pkg::IDX_LINE_ESTORE: begin
          // Written value against stored value gives the rising edge
          next_st.lrst_p  = pwdata[elc_pkg::BIT_LINE_RST] &&
                            !st.line_and_elastic_store_control[elc_pkg::BIT_LINE_RST];
          next_st.align_p = pwdata[elc_pkg::BIT_ES_ALIGN] && estore_sep_lt_half &&
                            !st.line_and_elastic_store_control[elc_pkg::BIT_ES_ALIGN];
          next_st.esrst_p = pwdata[elc_pkg::BIT_ES_RESET] &&
                            !st.line_and_elastic_store_control[elc_pkg::BIT_ES_RESET];
          next_st.line_and_elastic_store_control = pwdata[7:0];
        end
        elc_pkg::IDX_DRV_PATTERN: next_st.line_driver_and_pattern_control = pwdata[7:0];
        elc_pkg::IDX_COMMON_SEV:  next_st.tx_sync_signal_sel = pwdata[elc_pkg::BIT_TX_SYNC];
        elc_pkg::IDX_COMMON_SIX:  next_st.sw_reset = pwdata[elc_pkg::BIT_SW_RESET];
        default: begin
        end
      endcase
    end
    if (sw_clear) begin
      // Clears the reset bit itself, so the next write of one fires again
      next_st.local_loop_enable               = 1'b0;
      next_st.line_and_elastic_store_control  = elc_pkg::REG_RESET;
      next_st.line_driver_and_pattern_control = elc_pkg::REG_RESET;
      next_st.tx_sync_signal_sel              = 1'b0;
      next_st.sw_reset                        = 1'b0;
    end
    c4 = st.line_and_elastic_store_control;
    c5 = st.line_driver_and_pattern_control;
    // Disconnect pattern: ones alternate polarity as line coding requires
    if (tx_bit_en) begin
      next_st.pat_bit = !st.pat_bit;
      if (!st.pat_bit) begin
        next_st.pat_pol = !st.pat_pol;
      end
    end
    cur_p = c5[elc_pkg::BIT_DISC_PAT] ? (!st.pat_bit && !st.pat_pol) : tx_pos_in;
    cur_n = c5[elc_pkg::BIT_DISC_PAT] ? (!st.pat_bit && st.pat_pol) : tx_neg_in;
    // Transmit continues unchanged in loopback
    next_st.txp    = cur_p;
    next_st.txn    = cur_n;
    pos_drv        = !c5[elc_pkg::BIT_OPEN_DRAIN] || cur_p;
    neg_drv        = !c5[elc_pkg::BIT_OPEN_DRAIN] || cur_n;
    next_st.txp_oe = pos_drv;
    next_st.txn_oe = neg_drv;
    // Jitter attenuator sits in the loop path; its latency is outside this block
    next_st.jap = tx_pos_in;
    next_st.jan = tx_neg_in;
    next_st.rxp = st.local_loop_enable ? ja_out_pos : line_rx_pos;
    next_st.rxn = st.local_loop_enable ? ja_out_neg : line_rx_neg;
    next_st.term   = c5[elc_pkg::BIT_RX_TERM];
    next_st.txsync = c5[elc_pkg::BIT_SYNC_IF] ^ st.tx_sync_signal_sel;
    next_st.rxsync = c5[elc_pkg::BIT_SYNC_IF];
    next_st.txpat  = c5[elc_pkg::TX_PAT_MSB:elc_pkg::TX_PAT_LSB];
    next_st.rxpat  = c5[elc_pkg::RX_PAT_MSB:elc_pkg::RX_PAT_LSB];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata                = st.rdata;
  assign pready                = st.ready;
  assign pslverr               = st.slverr;
  assign line_tx_pos_o         = st.txp;
  assign line_tx_neg_o         = st.txn;
  assign line_tx_pos_oe        = st.txp_oe;
  assign line_tx_neg_oe        = st.txn_oe;
  assign ja_in_pos             = st.jap;
  assign ja_in_neg             = st.jan;
  assign rx_pos_out            = st.rxp;
  assign rx_neg_out            = st.rxn;
  assign line_side_reset_pulse = st.lrst_p;
  assign estore_align_pulse    = st.align_p;
  assign estore_reset_pulse    = st.esrst_p;
  assign rx_term_75            = st.term;
  assign tx_sync_mode          = st.txsync;
  assign rx_sync_mode          = st.rxsync;
  assign tx_pattern_mode       = st.txpat;
  assign rx_pattern_mode       = st.rxpat;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_loop_rx_select: assert property (st.local_loop_enable |=> rx_pos_out == $past(ja_out_pos))
    else $error("Loopback receive data not from attenuator");
  a_normal_rx_path: assert property (!st.local_loop_enable |=> rx_neg_out == $past(line_rx_neg))
    else $error("Normal receive data not from line");
  a_tx_unchanged: assert property (!c5[elc_pkg::BIT_DISC_PAT] |=> line_tx_pos_o == $past(tx_pos_in))
    else $error("Transmit data altered");
  a_loop_ja_feed: assert property (##1 ja_in_neg == $past(tx_neg_in))
    else $error("Attenuator not fed with transmit data");
  a_lrst_single: assert property (line_side_reset_pulse |=> !line_side_reset_pulse)
    else $error("Line reset pulse longer than one cycle");
  a_lrst_cause: assert property (line_side_reset_pulse |-> c4[elc_pkg::BIT_LINE_RST] && $past(wr))
    else $error("Line reset pulse without rising write");
  a_align_cond: assert property (estore_align_pulse |-> $past(estore_sep_lt_half))
    else $error("Align issued with separation at half frame");
  a_esrst_cause: assert property (estore_reset_pulse |-> c4[elc_pkg::BIT_ES_RESET] && $past(wr))
    else $error("Elastic store reset without rising write");
  a_open_drain: assert property (c5[elc_pkg::BIT_OPEN_DRAIN] ##1 c5[elc_pkg::BIT_OPEN_DRAIN]
                                 |-> line_tx_pos_oe == line_tx_pos_o)
    else $error("Open drain output enable wrong");
  a_sync_decode: assert property (##1 tx_sync_mode == ($past(c5[elc_pkg::BIT_SYNC_IF]) ^ $past(st.tx_sync_signal_sel)))
    else $error("Sync decode wrong");
  a_sw_clear: assert property (sw_clear |=> c5 == elc_pkg::REG_RESET && !st.local_loop_enable)
    else $error("Software reset did not clear registers");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("Ready held longer than one cycle");

  c_loop_on: cover property (!st.local_loop_enable ##1 st.local_loop_enable);
  c_align: cover property (estore_align_pulse);
  c_sw_reset: cover property (sw_clear);
  c_disc_pat: cover property (c5[elc_pkg::BIT_DISC_PAT] && tx_bit_en);
endmodule

// ==== elc_far_end.sv ====
// Far-end model: line receive source, jitter attenuator echo and receive slot stream
`timescale 1ns/10ps
module elc_far_end (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       line_level,
  input  wire logic       ja_in_pos,
  input  wire logic       ja_in_neg,
  output logic            line_rx_pos,
  output logic            line_rx_neg,
  output logic            ja_out_pos,
  output logic            ja_out_neg,
  output logic [4:0]      rx_slot_num,
  output logic [7:0]      rx_slot_data,
  output logic            rx_slot_valid
);
  // Dual rail always opposite so loop and line data differ
  assign line_rx_pos = line_level;
  assign line_rx_neg = ~line_level;
  // Attenuator as one register stage, no smoothing modelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ja_out_pos  <= 1'b0;
      ja_out_neg  <= 1'b0;
      rx_slot_num <= 5'h00;
    end else begin
      ja_out_pos  <= ja_in_pos;
      ja_out_neg  <= ja_in_neg;
      rx_slot_num <= rx_slot_num + 5'h01;
    end
  end
  // Data names its own slot so a wrong capture shows
  assign rx_slot_data  = {3'h0, rx_slot_num} + 8'h40;
  assign rx_slot_valid = 1'b1;
endmodule

// ==== tb.sv ====
// Self-checking bench for the line control block
`timescale 1ns/10ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ones;
  logic        tx_pos_in, tx_neg_in, tx_bit_en, line_level, sep_lt;
  logic        tpo, tpoe, tno, tnoe, rxp, rxn, jip, jin, jop, jon, lrp, lrn;
  logic        p_lrst, p_alg, p_esr, term75, txs, rxs, sval;
  logic [1:0]  txpm, rxpm;
  logic [4:0]  snum;
  logic [7:0]  sdat;
  int          err_total, n_tests, n_lrst, n_alg, n_esr;

  elc_line_ctrl u_elc_line_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_pos_in(tx_pos_in), .tx_neg_in(tx_neg_in), .tx_bit_en(tx_bit_en),
    .line_tx_pos_o(tpo), .line_tx_pos_oe(tpoe), .line_tx_neg_o(tno), .line_tx_neg_oe(tnoe),
    .line_rx_pos(lrp), .line_rx_neg(lrn), .ja_in_pos(jip), .ja_in_neg(jin), .ja_out_pos(jop),
    .ja_out_neg(jon), .rx_pos_out(rxp), .rx_neg_out(rxn), .estore_sep_lt_half(sep_lt),
    .line_side_reset_pulse(p_lrst), .estore_align_pulse(p_alg), .estore_reset_pulse(p_esr),
    .rx_term_75(term75), .tx_sync_mode(txs), .rx_sync_mode(rxs), .tx_pattern_mode(txpm),
    .rx_pattern_mode(rxpm), .rx_slot_num(snum), .rx_slot_data(sdat), .rx_slot_valid(sval));
  elc_far_end u_elc_far_end (.pclk(pclk), .presetn(presetn), .line_level(line_level),
    .ja_in_pos(jip), .ja_in_neg(jin), .line_rx_pos(lrp), .line_rx_neg(lrn), .ja_out_pos(jop),
    .ja_out_neg(jon), .rx_slot_num(snum), .rx_slot_data(sdat), .rx_slot_valid(sval));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Pulses counted per edge, so a stuck pulse shows as an excess count
  always @(posedge pclk) begin
    if (p_lrst === 1'b1) n_lrst++;
    if (p_alg === 1'b1) n_alg++;
    if (p_esr === 1'b1) n_esr++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One transfer, then an idle edge so strobes never change twice in a step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #800000;
    err_total++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, tx_pos_in, tx_neg_in, tx_bit_en, line_level, sep_lt} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ones = 32'h0;
    {err_total, n_tests, n_lrst, n_alg, n_esr} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(12'h050, 32'h0);
    rdchk(12'h054, 32'h0);
    rdchk(12'h058, 32'h0);
    apb(12'h055, 1'b0, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Commands only once the clocks are settled
    wr(12'h054, 32'h05);
    rdchk(12'h054, 32'h05);
    wr(12'h054, 32'hE5);
    wr(12'h054, 32'hE5);
    wt(3);
    chk(n_lrst, 1);
    chk(n_alg, 0);
    chk(n_esr, 1);
    wr(12'h054, 32'h05);
    sep_lt <= 1'b1;
    wr(12'h054, 32'hE5);
    wt(3);
    chk({n_lrst[7:0], n_alg[7:0], n_esr[7:0]}, 32'h020102);
    wt(40);
    rdchk(12'h0C0, 32'h45);
    wr(12'h058, 32'h1B);
    wt(2);
    chk({term75, txpm, rxpm}, 32'h1B);
    rdchk(12'h058, 32'h1B);
    for (int i = 0; i < 4; i++) begin
      wr(12'h058, {26'h0, i[1], 5'h00});
      wr(12'h07C, {31'h0, i[0]});
      wt(2);
      chk({txs, rxs}, {30'h0, i[1] ^ i[0], i[1]});
    end
    wr(12'h07C, 32'h0);
    wr(12'h058, 32'h80);
    wt(3);
    chk({tpoe, tnoe}, 2'b00);
    tx_pos_in <= 1'b1;
    wt(3);
    chk({tpoe, tnoe}, 2'b10);
    wr(12'h058, 32'h00);
    tx_pos_in <= 1'b0;
    wt(3);
    chk({tpoe, tnoe}, 2'b11);
    tx_pos_in <= 1'b1;
    wt(4);
    chk({rxp, rxn}, 2'b01);
    wr(12'h050, 32'h40);
    wt(4);
    chk({rxp, rxn, tpo, tno}, 4'b1010);
    wr(12'h050, 32'h00);
    wt(4);
    chk({rxp, rxn}, 2'b01);
    // Input held at ones so normal data would give four marks, not two
    wr(12'h058, 32'h40);
    repeat (4) begin
      tx_bit_en <= 1'b1;
      @(posedge pclk);
      tx_bit_en <= 1'b0;
      wt(3);
      ones = ones + {31'h0, tpo | tno};
    end
    chk(ones, 32'h2);
    wr(12'h0BC, 32'h1);
    wt(2);
    rdchk(12'h054, 32'h0);
    rdchk(12'h058, 32'h0);
    summarize();
  end
endmodule
